/* core/usb_ctrl_defs.svh */
`ifndef USB_CTRL_DEFS_SVH
`define USB_CTRL_DEFS_SVH

// timing, address and detach defaults
`define SUSPEND_IDLE_MS       3
`define REF_CLK_KHZ           100000
`define SUSPEND_IDLE_CYCLES   (`SUSPEND_IDLE_MS * `REF_CLK_KHZ)
`define RESUME_MS             2
`define RESUME_CYCLES         (`RESUME_MS * `REF_CLK_KHZ)
`define ADDR_WIDTH            7
`define DEFAULT_ADDR          7'h00
`define DETACH_RESET          1'b1

`endif

/* core/usb_ctrl_pkg.sv */
package usb_ctrl_pkg;
  // line state seen by the device on the data pads
  typedef enum logic [1:0] {
    LINE_IDLE  = 2'b00,
    LINE_ACT   = 2'b01,
    LINE_RESET = 2'b10
  } line_state_t;

  // device-side suspend and resume progress
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_SUSPEND = 2'b01,
    ST_RESUME  = 2'b10
  } power_state_t;
endpackage

/* core/usb_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
// bus between the device and the host-side model
interface usb_link_if;
  logic       pullup_on;
  logic       device_resume;
  logic       host_active;
  logic       host_bus_reset;
  logic       token_valid;
  logic [6:0] token_addr;

  modport device (
    output pullup_on,
    output device_resume,
    input  host_active,
    input  host_bus_reset,
    input  token_valid,
    input  token_addr
  );
  modport host (
    input  pullup_on,
    input  device_resume,
    output host_active,
    output host_bus_reset,
    output token_valid,
    output token_addr
  );
endinterface
`default_nettype wire

/* core/sync_2ff.sv */
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for a level from outside the clock domain
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage read only by the second
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* core/usb_device_address_suspend_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "usb_ctrl_defs.svh"
module usb_device_address_suspend_ctrl #(
  parameter int SUSPEND_CYCLES = `SUSPEND_IDLE_CYCLES,
  parameter int RESUME_LEN     = `RESUME_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  usb_link_if.device      link,
  input  wire logic       controller_enable_bit,
  input  wire logic       freeze_usb_clock_bit,
  input  wire logic       addr_write,
  input  wire logic [6:0] addr_wdata,
  input  wire logic       addr_en_write,
  input  wire logic       addr_en_wdata,
  input  wire logic       detach_write,
  input  wire logic       detach_wdata,
  input  wire logic       remote_wakeup_enabled,
  input  wire logic       resume_req_write,
  input  wire logic       suspend_clear,
  input  wire logic       wakeup_clear,
  input  wire logic       suspend_int_en,
  input  wire logic       wakeup_int_en,
  output logic [6:0]      device_address_field,
  output logic            address_enable_bit,
  output logic            detach,
  output logic            suspend_flag,
  output logic            wakeup_flag,
  output logic            transceiver_suspended,
  output logic            resume_pending,
  output logic            irq,
  output logic            packet_accept,
  output logic [6:0]      active_address
);
  localparam int CNT_W = $clog2(SUSPEND_CYCLES + RESUME_LEN + 1);

  logic                bus_act;
  logic                bus_rst;
  logic                tok_valid;
  logic [6:0]          tok_addr;
  logic [CNT_W-1:0]    idle_cnt;
  logic [CNT_W-1:0]    resume_cnt;
  usb_ctrl_pkg::power_state_t pwr;
  logic                run;

  // link pins come from the host side, so they get synchronised
  sync_2ff #(.WIDTH(10)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       ({link.host_active, link.host_bus_reset, link.token_valid, link.token_addr}),
    .q       ({bus_act, bus_rst, tok_valid, tok_addr})
  );
  // clock freeze stops idle counting, suspend flag setting and packet accept; register writes, flag clears, resume and the wake path still run
  assign run = controller_enable_bit && !freeze_usb_clock_bit;

  wire       clear_addr     = !controller_enable_bit || bus_rst;
  wire [6:0] next_active    = (address_enable_bit && device_address_field != `DEFAULT_ADDR)
                              ? device_address_field : `DEFAULT_ADDR;
  wire       idle_done      = (idle_cnt >= CNT_W'(SUSPEND_CYCLES - 1));
  wire       resume_ok      = suspend_flag && remote_wakeup_enabled
                              && pwr == usb_ctrl_pkg::ST_SUSPEND;
  wire       resume_start   = resume_req_write && resume_ok;
  wire       resume_done    = (resume_cnt >= CNT_W'(RESUME_LEN - 1));
  wire       set_suspend_flag       = run && idle_done && !suspend_flag
                              && pwr == usb_ctrl_pkg::ST_ACTIVE;
  wire       set_wake       = bus_act && controller_enable_bit;

  // address field and enable, written separately by software
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      device_address_field <= `DEFAULT_ADDR;
      address_enable_bit   <= 1'b0;
    end
    else if (clear_addr)
    begin
      device_address_field <= `DEFAULT_ADDR;
      address_enable_bit   <= 1'b0;
    end
    else
    begin
      if (addr_write)
        device_address_field <= addr_wdata;
      if (addr_en_write)
        address_enable_bit <= addr_en_wdata;
    end
  end

  // packet filter: only the active address passes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_address <= `DEFAULT_ADDR;
      packet_accept  <= 1'b0;
    end
    else
    begin
      active_address <= next_active;
      packet_accept  <= run && tok_valid && tok_addr == next_active;
    end
  end

  // idle counter, restarted by any bus activity
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      idle_cnt <= '0;
    else if (bus_act || !run || suspend_flag)
      idle_cnt <= '0;
    else if (!idle_done)
      idle_cnt <= idle_cnt + CNT_W'(1);
  end

  // sticky flags; hardware set beats software clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      suspend_flag <= 1'b0;
      wakeup_flag  <= 1'b0;
    end
    else if (set_wake)
    begin
      wakeup_flag  <= 1'b1;
      suspend_flag <= 1'b0;
    end
    else if (set_suspend_flag)
    begin
      suspend_flag <= 1'b1;
      wakeup_flag  <= 1'b0;
    end
    else
    begin
      if (suspend_clear)
        suspend_flag <= 1'b0;
      if (wakeup_clear)
        wakeup_flag <= 1'b0;
    end
  end

  // power state: active, suspended, driving resume
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwr        <= usb_ctrl_pkg::ST_ACTIVE;
      resume_cnt <= '0;
    end
    else
    begin
      unique case (pwr)
        usb_ctrl_pkg::ST_ACTIVE:
          if (set_suspend_flag)
            pwr <= usb_ctrl_pkg::ST_SUSPEND;
        usb_ctrl_pkg::ST_SUSPEND:
          if (bus_act || !controller_enable_bit)
            pwr <= usb_ctrl_pkg::ST_ACTIVE;
          else if (resume_start)
          begin
            pwr        <= usb_ctrl_pkg::ST_RESUME;
            resume_cnt <= '0;
          end
        usb_ctrl_pkg::ST_RESUME:
          if (resume_done)
            pwr <= usb_ctrl_pkg::ST_ACTIVE;
          else
            resume_cnt <= resume_cnt + CNT_W'(1);
        default:
          pwr <= usb_ctrl_pkg::ST_ACTIVE;
      endcase
    end
  end

  // outputs registered: transceiver, resume drive, pull-up, interrupt
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      transceiver_suspended <= 1'b0;
      resume_pending        <= 1'b0;
      detach                <= `DETACH_RESET;
      irq                   <= 1'b0;
      link.pullup_on        <= 1'b0;
      link.device_resume    <= 1'b0;
    end
    else
    begin
      transceiver_suspended <= pwr == usb_ctrl_pkg::ST_SUSPEND;
      resume_pending        <= pwr == usb_ctrl_pkg::ST_RESUME;
      if (detach_write)
        detach <= detach_wdata;
      irq <= (suspend_flag && suspend_int_en) || (wakeup_flag && wakeup_int_en);
      link.pullup_on     <= !detach && controller_enable_bit;
      link.device_resume <= pwr == usb_ctrl_pkg::ST_RESUME;
    end
  end
endmodule
`default_nettype wire

/* core/usb_host_end.sv */
`timescale 1ns/100ps
`default_nettype none
// host party: drives activity, bus reset and tokens from its user side
module usb_host_end (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  usb_link_if.host        link,
  input  wire logic       send_activity,
  input  wire logic       send_bus_reset,
  input  wire logic       send_token,
  input  wire logic [6:0] token_address,
  output logic            device_connected,
  output logic            resume_seen
);
  logic [1:0] dev_sync;

  // device pins are foreign to this end, so synchronise
  sync_2ff #(.WIDTH(2)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       ({link.pullup_on, link.device_resume}),
    .q       (dev_sync)
  );

  // registered drive onto the link
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      link.host_active    <= 1'b0;
      link.host_bus_reset <= 1'b0;
      link.token_valid    <= 1'b0;
      link.token_addr     <= 7'h00;
      device_connected    <= 1'b0;
      resume_seen         <= 1'b0;
    end
    else
    begin
      link.host_active    <= send_activity || send_token;
      link.host_bus_reset <= send_bus_reset;
      link.token_valid    <= send_token;
      link.token_addr     <= token_address;
      device_connected    <= dev_sync[1];
      resume_seen         <= dev_sync[0];
    end
  end
endmodule
`default_nettype wire

/* test/usb_link_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// watches the wire between the two ends
module usb_link_properties #(
  parameter int SUSPEND_CYCLES = 20,
  parameter int RESUME_LEN     = 10
) (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       pullup_on,
  input wire logic       device_resume,
  input wire logic       host_active,
  input wire logic       host_bus_reset,
  input wire logic       token_valid,
  input wire logic [6:0] token_addr
);
  int idle_cnt;
  int res_cnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // run lengths; idle saturates so a long suspend never wraps it
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idle_cnt <= 0;
      res_cnt  <= 0;
    end
    else
    begin
      idle_cnt <= host_active ? 0 : (idle_cnt < SUSPEND_CYCLES ? idle_cnt + 1 : idle_cnt);
      res_cnt  <= device_resume ? res_cnt + 1 : 0;
    end
  end

  AST_DETACHED_AFTER_RESET: assert property ($fell(sys_rst) |-> !pullup_on ##1 !pullup_on)
    else $error("pull-up came on before software released detach");
  AST_QUIET_AFTER_RESET: assert property ($fell(sys_rst) |-> !device_resume [*2])
    else $error("resume driven right after reset");
  AST_RESUME_NEEDS_IDLE: assert property ($rose(device_resume) |-> idle_cnt >= SUSPEND_CYCLES)
    else $error("resume started without a suspended bus");
  AST_RESUME_LENGTH: assert property ($fell(device_resume) |-> res_cnt == RESUME_LEN)
    else $error("resume signalling has the wrong length");
  AST_RESUME_BOUNDED: assert property (device_resume |-> res_cnt < RESUME_LEN)
    else $error("resume signalling not ended by itself");
  AST_RESUME_GAP: assert property ($fell(device_resume) |-> !device_resume [*3])
    else $error("resume restarted right after it ended");

  // main traffic seen at least once
  cover property ($rose(device_resume));
  cover property (token_valid && token_addr == 7'h05);
  cover property ($rose(host_bus_reset));
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int SUSPEND_FLAG = 20;
  localparam int RES  = 10;
  logic       ref_clk = 1'b0;
  logic       sys_rst, controller_enable_bit, freeze_usb_clock_bit, addr_write;
  logic       addr_en_write, addr_en_wdata, detach_write, detach_wdata;
  logic       remote_wakeup_enabled, resume_req_write, suspend_clear, wakeup_clear;
  logic       suspend_int_en, wakeup_int_en, address_enable_bit, detach, suspend_flag;
  logic       wakeup_flag, transceiver_suspended, resume_pending, irq, packet_accept;
  logic       send_activity, send_bus_reset, send_token, device_connected, resume_seen;
  logic [6:0] addr_wdata, device_address_field, active_address, token_address;
  int         mismatches = 0;
  int         comparisons = 0;

  usb_link_if link();
  usb_device_address_suspend_ctrl #(.SUSPEND_CYCLES(SUSPEND_FLAG), .RESUME_LEN(RES))
    usb_device_address_suspend_ctrl_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .controller_enable_bit(controller_enable_bit),
    .freeze_usb_clock_bit(freeze_usb_clock_bit),
    .addr_write(addr_write), .addr_wdata(addr_wdata), .addr_en_write(addr_en_write),
    .addr_en_wdata(addr_en_wdata), .detach_write(detach_write), .detach_wdata(detach_wdata),
    .remote_wakeup_enabled(remote_wakeup_enabled), .resume_req_write(resume_req_write),
    .suspend_clear(suspend_clear), .wakeup_clear(wakeup_clear),
    .suspend_int_en(suspend_int_en), .wakeup_int_en(wakeup_int_en),
    .device_address_field(device_address_field), .address_enable_bit(address_enable_bit),
    .detach(detach), .suspend_flag(suspend_flag), .wakeup_flag(wakeup_flag),
    .transceiver_suspended(transceiver_suspended), .resume_pending(resume_pending),
    .irq(irq), .packet_accept(packet_accept), .active_address(active_address));
  usb_host_end usb_host_end_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .send_activity(send_activity),
    .send_bus_reset(send_bus_reset), .send_token(send_token), .token_address(token_address),
    .device_connected(device_connected), .resume_seen(resume_seen));
  usb_link_properties #(.SUSPEND_CYCLES(SUSPEND_FLAG), .RESUME_LEN(RES)) usb_link_properties_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .pullup_on(link.pullup_on),
    .device_resume(link.device_resume), .host_active(link.host_active),
    .host_bus_reset(link.host_bus_reset), .token_valid(link.token_valid),
    .token_addr(link.token_addr));

  always #5 ref_clk = ~ref_clk;

  // drives land 1 ns after the edge, clear of sampling
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask

  task automatic chk(input string name, input logic [6:0] seen, input logic [6:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // bounded wait; running out ends the run
  task automatic wait_for(input string name, ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 100)
    begin
      tick();
      n++;
    end
    chk(name, {6'h00, s}, {6'h00, v});
    if (s !== v)
      test_done();
  endtask

  // token crosses 4 edges later; window of 6 covers it
  task automatic tok(input logic [6:0] a, input logic exp);
    logic seen;
    seen = 1'b0;
    token_address = a;
    pulse(send_token);
    repeat (6)
    begin
      tick();
      seen |= packet_accept;
    end
    chk("accept", {6'h00, seen}, {6'h00, exp});
  endtask

  initial
  begin
    {controller_enable_bit, freeze_usb_clock_bit, addr_write, addr_en_write, addr_en_wdata} = '0;
    {detach_write, detach_wdata, remote_wakeup_enabled, resume_req_write, suspend_clear} = '0;
    {wakeup_clear, suspend_int_en, wakeup_int_en, send_activity, send_bus_reset} = '0;
    {send_token, addr_wdata, token_address} = '0;
    sys_rst = 1'b1;
    controller_enable_bit = 1'b1;
    tick(5);
    sys_rst = 1'b0;
    chk("field", device_address_field, 7'h00);
    chk("detach", {6'h00, detach}, 7'h01);
    for (int i = 0; i < 3; i++)
    begin
      detach_wdata = i[0] ^ 1'b0 ? 1'b1 : 1'b0;
      pulse(detach_write);
      tick(6);
      chk("connected", {6'h00, device_connected}, {6'h00, ~detach_wdata});
    end
    addr_wdata = 7'h05;
    pulse(addr_write);
    chk("field", device_address_field, 7'h05);
    chk("active", active_address, 7'h00);
    tok(7'h00, 1'b1);
    tok(7'h05, 1'b0);
    addr_en_wdata = 1'b1;
    pulse(addr_en_write);
    tick();
    chk("active", active_address, 7'h05);
    chk("enable", {6'h00, address_enable_bit}, 7'h01);
    tok(7'h05, 1'b1);
    tok(7'h03, 1'b0);
    pulse(send_bus_reset);
    tick(5);
    chk("field", device_address_field, 7'h00);
    chk("enable", {6'h00, address_enable_bit}, 7'h00);
    pulse(addr_write);
    controller_enable_bit = 1'b0;
    tick(2);
    chk("field", device_address_field, 7'h00);
    controller_enable_bit = 1'b1;
    remote_wakeup_enabled = 1'b1;
    pulse(resume_req_write);
    tick();
    chk("pending", {6'h00, resume_pending}, 7'h00);
    wait_for("suspend", suspend_flag, 1'b1);
    tick();
    chk("xcvr", {5'h00, transceiver_suspended, wakeup_flag}, 7'h02);
    chk("irq", {6'h00, irq}, 7'h00);
    suspend_int_en = 1'b1;
    tick(2);
    chk("irq", {6'h00, irq}, 7'h01);
    remote_wakeup_enabled = 1'b0;
    pulse(resume_req_write);
    tick();
    chk("pending", {6'h00, resume_pending}, 7'h00);
    remote_wakeup_enabled = 1'b1;
    pulse(resume_req_write);
    tick();
    chk("pending", {6'h00, resume_pending}, 7'h01);
    wait_for("resume", resume_seen, 1'b1);
    wait_for("pending", resume_pending, 1'b0);
    pulse(suspend_clear);
    chk("suspend", {6'h00, suspend_flag}, 7'h00);
    freeze_usb_clock_bit = 1'b1;
    tok(7'h00, 1'b0);
    freeze_usb_clock_bit = 1'b0;
    wait_for("suspend", suspend_flag, 1'b1);
    send_activity = 1'b1;
    tick(2);
    send_activity = 1'b0;
    wait_for("wakeup", wakeup_flag, 1'b1);
    chk("suspend", {6'h00, suspend_flag}, 7'h00);
    suspend_int_en = 1'b0;
    tick(2);
    chk("irq", {6'h00, irq}, 7'h00);
    wakeup_int_en = 1'b1;
    tick(2);
    chk("irq", {6'h00, irq}, 7'h01);
    pulse(wakeup_clear);
    chk("wakeup", {6'h00, wakeup_flag}, 7'h00);
    test_done();
  end
endmodule
`default_nettype wire
